// ---- pkg/ptl_cfg.svh ----
// Register offsets, reset values and timing counts of the tension control loop.
`ifndef PTL_CFG_SVH
`define PTL_CFG_SVH

`define PTL_OFS_ENABLE      8'hc2
`define PTL_OFS_CLEAR       8'hc3
`define PTL_OFS_PGAIN       8'hc4
`define PTL_OFS_ITIME       8'hc5
`define PTL_OFS_DLEVEL      8'hc6
`define PTL_OFS_DINTERVAL   8'hc7
`define PTL_OFS_IZERO       8'hc8
`define PTL_OFS_ISIGN       8'hc9
`define PTL_OFS_IRATE       8'hca
`define PTL_OFS_IWINDOW     8'hcb
`define PTL_OFS_WSELECT     8'hcc
`define PTL_OFS_TARGET      8'hcd
`define PTL_OFS_MEASURED    8'hce
`define PTL_OFS_ERROR       8'hcf
`define PTL_OFS_TRIM        8'hd0
`define PTL_OFS_FLOOR       8'hd1
`define PTL_OFS_EXTSCALE    8'hd2
`define PTL_OFS_OUTSIGN     8'hd3
`define PTL_OFS_OUTPUT      8'hd4
`define PTL_OFS_PCOMP       8'hd5
`define PTL_OFS_ICOMP       8'hd6
`define PTL_OFS_DCOMP       8'hd7
`define PTL_OFS_ISAT        8'hd8
`define PTL_OFS_IHOLD       8'hd9

`define PTL_RST_ENABLE      16'h0000
`define PTL_RST_CLEAR       16'h0000
`define PTL_RST_PGAIN       16'h01f4
`define PTL_RST_ITIME       16'h2710
`define PTL_RST_DLEVEL      16'h0000
`define PTL_RST_DINTERVAL   16'h0144
`define PTL_RST_IZERO       16'h0000
`define PTL_RST_ISIGN       16'h0001
`define PTL_RST_IRATE       16'h0000
`define PTL_RST_IWINDOW     16'h0000
`define PTL_RST_WSELECT     16'h0000
`define PTL_RST_TARGET      16'h0000
`define PTL_RST_MEASURED    16'h0000
`define PTL_RST_TRIM        16'h2710
`define PTL_RST_FLOOR       16'h0000
`define PTL_RST_EXTSCALE    16'h2710
`define PTL_RST_OUTSIGN     16'h0000

`define PTL_FULL_SCALE      16'h2710
`define PTL_GAIN_UNIT       16'h0064
`define PTL_ACC_FRAC        16
`define PTL_CLK_MHZ         200
`define PTL_BASE_TICK_NS    10000
`define PTL_BASE_TICK_CYC   ((`PTL_BASE_TICK_NS * `PTL_CLK_MHZ) / 1000)
`define PTL_UPDATE_TICK_NS  1000000
`define PTL_UPDATE_BASES    (`PTL_UPDATE_TICK_NS / `PTL_BASE_TICK_NS)

`endif

// ---- pkg/ptl_pkg.sv ----
// Types shared by the tension control loop and its bench.
package ptl_pkg;

  typedef struct packed {
    logic        write;
    logic        read;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } ptl_reg_req_type;

  typedef struct packed {
    logic signed [15:0] error;
    logic signed [15:0] prop;
    logic signed [15:0] integ;
    logic signed [15:0] deriv;
    logic signed [15:0] out;
    logic               integ_sat;
    logic               integ_hold;
  } ptl_status_type;

endpackage

// ---- logic/ptl_loop.sv ----
// Tension control loop with proportional, integral and derivative action.
// Operation
// - Disabled loop forces components and output zero.
// - Clear setting holds components and output zero.
// - Error is target minus measured, read-only.
// - Proportional term is error times gain.
// - Integral time sets zero-to-full ramp time in linear mode.
// - Derivative scaled by level; zero disables.
// - Derivative sampling interval set in base ticks of 0.01 ms.
// - Integral zero force holds integral at zero.
// - Sign select restricts integral to non-negative.
// - Rate select picks linear or error-proportional integration.
// - Errors inside window are not integrated.
// - Saturated monitor stops integral from falling.
// - Hold flag reads one while integral held.
// - Monitor select zero disables anti-windup.
// - Signed trim scales correction, negative inverts.
// - External scale with floor scale minimum.
// - Output sign select limits final output.
// - Final output readable after all scaling.
// - Saturation flag at integral full scale.
// - Components readable separately for tuning.
`include "ptl_cfg.svh"

module ptl_loop
  import ptl_pkg::*;
#(
  parameter int unsigned BASE_TICK_CYC = `PTL_BASE_TICK_CYC
) (
  input  wire logic            clk,
  input  wire logic            reset_n,
  input  wire ptl_reg_req_type reg_req,
  input  wire logic            monitor_saturated,
  output logic [15:0]          reg_rdata,
  output logic                 reg_rvalid,
  output ptl_status_type       status
);

  localparam logic signed [33:0] ACC_LIMIT =
    34'($signed({1'b0, `PTL_FULL_SCALE})) <<< `PTL_ACC_FRAC;

  // Saturate a wide signed value to a 16-bit signed register value.
  function automatic logic signed [15:0] sat16(input logic signed [47:0] v);
    logic signed [15:0] r;
    r = v[15:0];
    if (v > 48'sd32767) begin
      r = 16'sh7fff;
    end else if (v < -48'sd32768) begin
      r = -16'sh8000;
    end
    return r;
  endfunction

  logic [15:0] loop_enable, loop_clear, prop_gain, integ_time, deriv_level;
  logic [15:0] deriv_sample_interval, integ_zero_force, integ_sign_select;
  logic [15:0] integ_rate_select, integ_ignore_window, windup_monitor_select;
  logic [15:0] target_value, measured_value, correction_trim, floor_scale;
  logic [15:0] external_scale, output_sign_select;

  // Settings written by the register port.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      loop_enable           <= `PTL_RST_ENABLE;
      loop_clear            <= `PTL_RST_CLEAR;
      prop_gain             <= `PTL_RST_PGAIN;
      integ_time            <= `PTL_RST_ITIME;
      deriv_level           <= `PTL_RST_DLEVEL;
      deriv_sample_interval <= `PTL_RST_DINTERVAL;
      integ_zero_force      <= `PTL_RST_IZERO;
      integ_sign_select     <= `PTL_RST_ISIGN;
      integ_rate_select     <= `PTL_RST_IRATE;
      integ_ignore_window   <= `PTL_RST_IWINDOW;
      windup_monitor_select <= `PTL_RST_WSELECT;
      target_value          <= `PTL_RST_TARGET;
      measured_value        <= `PTL_RST_MEASURED;
      correction_trim       <= `PTL_RST_TRIM;
      floor_scale           <= `PTL_RST_FLOOR;
      external_scale        <= `PTL_RST_EXTSCALE;
      output_sign_select    <= `PTL_RST_OUTSIGN;
    end else if (reg_req.write) begin
      case (reg_req.addr)
        `PTL_OFS_ENABLE:    loop_enable           <= reg_req.wdata;
        `PTL_OFS_CLEAR:     loop_clear            <= reg_req.wdata;
        `PTL_OFS_PGAIN:     prop_gain             <= reg_req.wdata;
        `PTL_OFS_ITIME:     integ_time            <= reg_req.wdata;
        `PTL_OFS_DLEVEL:    deriv_level           <= reg_req.wdata;
        `PTL_OFS_DINTERVAL: deriv_sample_interval <= reg_req.wdata;
        `PTL_OFS_IZERO:     integ_zero_force      <= reg_req.wdata;
        `PTL_OFS_ISIGN:     integ_sign_select     <= reg_req.wdata;
        `PTL_OFS_IRATE:     integ_rate_select     <= reg_req.wdata;
        `PTL_OFS_IWINDOW:   integ_ignore_window   <= reg_req.wdata;
        `PTL_OFS_WSELECT:   windup_monitor_select <= reg_req.wdata;
        `PTL_OFS_TARGET:    target_value          <= reg_req.wdata;
        `PTL_OFS_MEASURED:  measured_value        <= reg_req.wdata;
        `PTL_OFS_TRIM:      correction_trim       <= reg_req.wdata;
        `PTL_OFS_FLOOR:     floor_scale           <= reg_req.wdata;
        `PTL_OFS_EXTSCALE:  external_scale        <= reg_req.wdata;
        `PTL_OFS_OUTSIGN:   output_sign_select    <= reg_req.wdata;
        default: ;
      endcase
    end
  end

  // Tick generation: a 10 us base tick paces derivative sampling, and every
  // hundredth base tick is the loop update tick.
  logic [15:0] base_cnt;
  logic [7:0]  upd_cnt;
  logic        base_tick, upd_tick;
  assign base_tick = (base_cnt == 16'(BASE_TICK_CYC - 1));
  assign upd_tick  = base_tick && (upd_cnt == 8'(`PTL_UPDATE_BASES - 1));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      base_cnt <= 16'h0000;
      upd_cnt  <= 8'h00;
    end else begin
      base_cnt <= base_tick ? 16'h0000 : base_cnt + 16'h0001;
      if (base_tick) begin
        upd_cnt <= upd_tick ? 8'h00 : upd_cnt + 8'h01;
      end
    end
  end

  logic signed [15:0] err_now;
  logic        [15:0] err_mag;
  assign err_now = sat16(48'($signed(target_value)) - 48'($signed(measured_value)));
  assign err_mag = err_now[15] ? 16'(-32'($signed(err_now))) : err_now;

  // Derivative sampling; the interval counts base ticks of 0.01 ms.
  logic [15:0]        dint_cnt;
  logic signed [15:0] err_sample, err_delta;
  logic               running;
  assign running = (loop_enable != 16'h0000) && (loop_clear != 16'h0001);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dint_cnt   <= 16'h0000;
      err_sample <= 16'sh0000;
      err_delta  <= 16'sh0000;
    end else if (!running) begin
      dint_cnt   <= 16'h0000;
      err_sample <= err_now;
      err_delta  <= 16'sh0000;
    end else if (base_tick) begin
      if (dint_cnt + 16'h0001 >= deriv_sample_interval) begin
        dint_cnt   <= 16'h0000;
        err_sample <= err_now;
        err_delta  <= sat16(48'(err_now) - 48'(err_sample));
      end else begin
        dint_cnt <= dint_cnt + 16'h0001;
      end
    end
  end

  // Next values of all terms, taken into the status only on the update tick.
  logic signed [33:0] acc, next_acc, acc_sum;
  logic        [31:0] step, step_num;
  logic        [15:0] itime_eff;
  logic               in_window, hold_now;
  logic signed [15:0] next_prop, next_integ, next_deriv, sum, corr, eff_scale, next_out;

  always_comb begin
    next_prop = sat16(48'(err_now) * 48'($signed(prop_gain)) /
                      48'($signed({1'b0, `PTL_GAIN_UNIT})));
    next_deriv = sat16(48'(err_delta) * 48'($signed(deriv_level)) /
                       48'($signed({1'b0, `PTL_FULL_SCALE})));
    itime_eff = (integ_time == 16'h0000) ? 16'h0001 : integ_time;
    step_num  = (integ_rate_select == 16'h0001) ? {err_mag, 16'h0000}
                                                : {`PTL_FULL_SCALE, 16'h0000};
    step      = step_num / 32'(itime_eff);
    in_window = (err_mag <= integ_ignore_window) || (err_now == 16'sh0000);
    hold_now  = (windup_monitor_select != 16'h0000) && monitor_saturated
                && err_now[15] && !in_window && (integ_zero_force != 16'h0001);
    if (in_window || hold_now) begin
      acc_sum = acc;
    end else if (err_now[15]) begin
      acc_sum = acc - 34'($signed({1'b0, step}));
    end else begin
      acc_sum = acc + 34'($signed({1'b0, step}));
    end
    next_acc = acc_sum;
    if (acc_sum > ACC_LIMIT) begin
      next_acc = ACC_LIMIT;
    end else if (acc_sum < -ACC_LIMIT) begin
      next_acc = -ACC_LIMIT;
    end
    if (integ_sign_select == 16'h0000 && next_acc < 34'sd0) begin
      next_acc = 34'sd0;
    end
    if (integ_zero_force == 16'h0001) begin
      next_acc = 34'sd0;
    end
    next_integ = 16'(next_acc >>> `PTL_ACC_FRAC);
    sum  = sat16(48'(next_prop) + 48'(next_integ) + 48'(next_deriv));
    corr = sat16(48'(sum) * 48'($signed(correction_trim)) /
                 48'($signed({1'b0, `PTL_FULL_SCALE})));
    // Taking the larger of the two keeps some authority when the line stops.
    eff_scale = ($signed(external_scale) > $signed(floor_scale)) ?
                $signed(external_scale) : $signed(floor_scale);
    next_out = sat16(48'(corr) * 48'(eff_scale) / 48'($signed({1'b0, `PTL_FULL_SCALE})));
    if ((output_sign_select == 16'h0001 && next_out < 16'sh0000) ||
        (output_sign_select == 16'h0002 && next_out > 16'sh0000)) begin
      next_out = 16'sh0000;
    end
  end

  // Loop state, updated once per update tick.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      acc               <= 34'sd0;
      status.prop       <= 16'sh0000;
      status.integ      <= 16'sh0000;
      status.deriv      <= 16'sh0000;
      status.out        <= 16'sh0000;
      status.integ_sat  <= 1'b0;
      status.integ_hold <= 1'b0;
    end else if (!running) begin
      acc               <= 34'sd0;
      status.prop       <= 16'sh0000;
      status.integ      <= 16'sh0000;
      status.deriv      <= 16'sh0000;
      status.out        <= 16'sh0000;
      status.integ_sat  <= 1'b0;
      status.integ_hold <= 1'b0;
    end else if (upd_tick) begin
      acc               <= next_acc;
      status.prop       <= next_prop;
      status.integ      <= next_integ;
      status.deriv      <= next_deriv;
      status.out        <= next_out;
      // The flag follows the reported integral, which rounds down near the negative limit.
      status.integ_sat  <= (next_integ == $signed(`PTL_FULL_SCALE)) ||
                           (next_integ == -$signed(`PTL_FULL_SCALE));
      status.integ_hold <= hold_now;
    end
  end

  // The error follows the settings every cycle rather than per tick.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status.error <= 16'sh0000;
    end else begin
      status.error <= err_now;
    end
  end

  // Register reads answer one cycle later; unmapped offsets read zero.
  logic [15:0] next_rdata;
  always_comb begin
    unique case (reg_req.addr)
      `PTL_OFS_ENABLE:    next_rdata = loop_enable;
      `PTL_OFS_CLEAR:     next_rdata = loop_clear;
      `PTL_OFS_PGAIN:     next_rdata = prop_gain;
      `PTL_OFS_ITIME:     next_rdata = integ_time;
      `PTL_OFS_DLEVEL:    next_rdata = deriv_level;
      `PTL_OFS_DINTERVAL: next_rdata = deriv_sample_interval;
      `PTL_OFS_IZERO:     next_rdata = integ_zero_force;
      `PTL_OFS_ISIGN:     next_rdata = integ_sign_select;
      `PTL_OFS_IRATE:     next_rdata = integ_rate_select;
      `PTL_OFS_IWINDOW:   next_rdata = integ_ignore_window;
      `PTL_OFS_WSELECT:   next_rdata = windup_monitor_select;
      `PTL_OFS_TARGET:    next_rdata = target_value;
      `PTL_OFS_MEASURED:  next_rdata = measured_value;
      `PTL_OFS_ERROR:     next_rdata = status.error;
      `PTL_OFS_TRIM:      next_rdata = correction_trim;
      `PTL_OFS_FLOOR:     next_rdata = floor_scale;
      `PTL_OFS_EXTSCALE:  next_rdata = external_scale;
      `PTL_OFS_OUTSIGN:   next_rdata = output_sign_select;
      `PTL_OFS_OUTPUT:    next_rdata = status.out;
      `PTL_OFS_PCOMP:     next_rdata = status.prop;
      `PTL_OFS_ICOMP:     next_rdata = status.integ;
      `PTL_OFS_DCOMP:     next_rdata = status.deriv;
      `PTL_OFS_ISAT:      next_rdata = {15'h0000, status.integ_sat};
      `PTL_OFS_IHOLD:     next_rdata = {15'h0000, status.integ_hold};
      default:            next_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata  <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rdata  <= reg_req.read ? next_rdata : reg_rdata;
      reg_rvalid <= reg_req.read;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence stopped_s;
    !running ##1 1'b1;
  endsequence

  sequence idle_run_s;
    running && !upd_tick;
  endsequence

  stopped_zero_a: assert property (stopped_s |->
    status.prop == 0 && status.integ == 0 && status.deriv == 0 && status.out == 0)
    else $error("stopped loop left a nonzero term");
  error_follow_a: assert property ($stable(target_value) && $stable(measured_value)
    |=> status.error == $past(target_value) - $past(measured_value)
        || status.error == 16'sh7fff || status.error == -16'sh8000)
    else $error("error value does not follow target and measured");
  zero_force_a: assert property (upd_tick && running && integ_zero_force == 16'h0001
    |=> status.integ == 0)
    else $error("forced integral is not zero");
  integ_sign_a: assert property (integ_sign_select == 16'h0000 && upd_tick
    |=> status.integ >= 0)
    else $error("integral went negative in unipolar mode");
  out_sign_a: assert property (upd_tick && running && output_sign_select == 16'h0001
    |=> status.out >= 0)
    else $error("positive only output went negative");
  hold_flag_a: assert property (upd_tick && running
    |=> status.integ_hold == ($past(windup_monitor_select) != 0 && $past(hold_now)))
    else $error("hold flag disagrees with anti-windup state");
  hold_no_fall_a: assert property (upd_tick && running && hold_now
    |=> status.integ >= $past(status.integ))
    else $error("integral fell while held");
  sat_flag_a: assert property (upd_tick && running |=>
    status.integ_sat == (status.integ == 16'sh2710 || status.integ == -16'sh2710))
    else $error("saturation flag wrong");
  tick_gap_a: assert property (upd_tick |=> !upd_tick [*8])
    else $error("update ticks too close");
  read_answer_a: assert property (reg_req.read |=> reg_rvalid)
    else $error("read not answered");
  prop_sign_a: assert property (upd_tick && running && err_now >= 0
    && !prop_gain[15]
    |=> status.prop >= 0)
    else $error("proportional term has the wrong sign");
  deriv_off_a: assert property (upd_tick && running && deriv_level == 16'h0000
    |=> status.deriv == 0)
    else $error("derivative term not disabled at zero level");
  deriv_hold_a: assert property (running && !base_tick |=> $stable(err_delta))
    else $error("derivative sample changed between base ticks");
  window_hold_a: assert property (upd_tick && running && in_window
    && integ_sign_select == 16'h0001 && integ_zero_force != 16'h0001
    |=> status.integ == $past(status.integ))
    else $error("integral moved inside the ignore window");
  out_neg_a: assert property (upd_tick && running && output_sign_select == 16'h0002
    |=> status.out <= 0)
    else $error("negative only output went positive");
  between_ticks_a: assert property (idle_run_s |=>
    $stable(status.out) && $stable(status.prop) &&
    $stable(status.integ) && $stable(status.deriv))
    else $error("terms changed between update ticks");

endmodule

// ---- tb/ptl_link_src.sv ----
// Linked source block that reports whether the monitored output parameter is saturated.
module ptl_link_src (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic sat_cmd,
  output logic      monitor_saturated
);
  timeunit 1ns;
  timeprecision 1ps;

  // The linked parameter changes only on the processing clock, so the level is registered.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      monitor_saturated <= 1'b0;
    end else begin
      monitor_saturated <= sat_cmd;
    end
  end
endmodule

// ---- tb/tb_pid_tension_loop.sv ----
// Bench for the tension control loop: registers, output scaling and integral behaviour.
`include "ptl_cfg.svh"

module tb_pid_tension_loop
  import ptl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int TK = 400;

  logic            clk = 1'b0;
  logic            reset_n = 1'b0;
  ptl_reg_req_type req = '0;
  logic            sat_cmd = 1'b0;
  logic            monitor_saturated;
  logic [15:0]     reg_rdata;
  logic            reg_rvalid;
  ptl_status_type  status;
  logic [15:0]     rdv;
  int              n_fail = 0;
  int              num_checks = 0;
  int              cyc = 0;

  always #2.5 clk = ~clk;

  always @(posedge clk) begin
    if (reset_n) cyc <= cyc + 1;
  end

  // A short base tick keeps one update tick at 400 cycles.
  ptl_loop #(.BASE_TICK_CYC(4)) dut (
    .clk(clk), .reset_n(reset_n), .reg_req(req), .monitor_saturated(monitor_saturated),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .status(status));

  ptl_link_src link (.clk(clk), .reset_n(reset_n), .sat_cmd(sat_cmd),
    .monitor_saturated(monitor_saturated));

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk);
    req = '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    req = '0;
  endtask

  // Read data is only trusted in the cycle that the valid pulse marks.
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge clk);
    req = '{write: 1'b0, read: 1'b1, addr: a, wdata: 16'h0000};
    @(negedge clk);
    d = (reg_rvalid === 1'b1) ? reg_rdata : 16'hxxxx;
    req = '0;
  endtask

  // Ends ten cycles after an update tick, leaving room for writes before the next one.
  task automatic sync_tick();
    @(negedge clk);
    while (cyc % TK != 10) @(negedge clk);
  endtask

  task automatic chk_st(input logic [15:0] p, i, o, input string what);
    chk(status.prop, p, what);
    chk(status.integ, i, what);
    chk(status.deriv, 16'h0000, what);
    chk(status.out, o, what);
  endtask

  task automatic step(input logic [7:0] a, input logic [15:0] d, o, input string what);
    wr(a, d);
    sync_tick();
    chk(status.out, o, what);
  endtask

  task automatic t_reset();
    logic [15:0] rst [18];
    rst = '{`PTL_RST_ENABLE, `PTL_RST_CLEAR, `PTL_RST_PGAIN, `PTL_RST_ITIME,
            `PTL_RST_DLEVEL, `PTL_RST_DINTERVAL, `PTL_RST_IZERO, `PTL_RST_ISIGN,
            `PTL_RST_IRATE, `PTL_RST_IWINDOW, `PTL_RST_WSELECT, `PTL_RST_TARGET,
            `PTL_RST_MEASURED, 16'h0000, `PTL_RST_TRIM, `PTL_RST_FLOOR,
            `PTL_RST_EXTSCALE, `PTL_RST_OUTSIGN};
    chk_st(16'h0000, 16'h0000, 16'h0000, "idle status");
    for (int k = 0; k < 18; k++) begin
      rd(8'hc2 + 8'(k), rdv);
      chk(rdv, rst[k], "reset value");
    end
    wr(`PTL_OFS_ERROR, 16'h1234);
    rd(`PTL_OFS_ERROR, rdv);
    chk(rdv, 16'h0000, "read-only write");
    rd(8'h10, rdv);
    chk(rdv, 16'h0000, "unmapped read");
    $display("test reset done");
  endtask

  task automatic t_error();
    wr(`PTL_OFS_TARGET, 16'h03e8);
    wr(`PTL_OFS_MEASURED, 16'h012c);
    rd(`PTL_OFS_ERROR, rdv);
    chk(rdv, 16'h02bc, "positive error");
    wr(`PTL_OFS_TARGET, 16'h0064);
    wr(`PTL_OFS_MEASURED, 16'h0190);
    rd(`PTL_OFS_ERROR, rdv);
    chk(rdv, 16'hfed4, "negative error");
    chk(status.error, 16'hfed4, "error status");
    $display("test error done");
  endtask

  task automatic t_prop();
    wr(`PTL_OFS_IZERO, 16'h0001);
    wr(`PTL_OFS_TARGET, 16'h03e8);
    wr(`PTL_OFS_MEASURED, 16'h0000);
    wr(`PTL_OFS_ENABLE, 16'h0001);
    sync_tick();
    sync_tick();
    chk_st(16'h1388, 16'h0000, 16'h1388, "gain five");
    rd(`PTL_OFS_OUTPUT, rdv);
    chk(rdv, 16'h1388, "output register");
    step(`PTL_OFS_TRIM, 16'hec78, 16'hf63c, "negative trim");
    step(`PTL_OFS_OUTSIGN, 16'h0001, 16'h0000, "positive only");
    step(`PTL_OFS_OUTSIGN, 16'h0002, 16'hf63c, "negative only");
    wr(`PTL_OFS_TRIM, 16'h2710);
    step(`PTL_OFS_OUTSIGN, 16'h0000, 16'h1388, "both signs");
    wr(`PTL_OFS_EXTSCALE, 16'h0000);
    step(`PTL_OFS_FLOOR, 16'h1388, 16'h09c4, "floor scale");
    step(`PTL_OFS_EXTSCALE, 16'h1f40, 16'h0fa0, "external scale");
    wr(`PTL_OFS_FLOOR, 16'h0000);
    step(`PTL_OFS_EXTSCALE, 16'h2710, 16'h1388, "full scale");
    $display("test prop done");
  endtask

  task automatic t_off();
    wr(`PTL_OFS_CLEAR, 16'h0001);
    repeat (2) @(negedge clk);
    chk_st(16'h0000, 16'h0000, 16'h0000, "clear held");
    step(`PTL_OFS_CLEAR, 16'h0000, 16'h1388, "clear released");
    wr(`PTL_OFS_ENABLE, 16'h0000);
    repeat (2) @(negedge clk);
    chk_st(16'h0000, 16'h0000, 16'h0000, "disabled");
    $display("test off done");
  endtask

  // Proportional gain is zero here, so the output equals the integral alone.
  task automatic icase(input logic [15:0] tgt, input int isg, irt, win, wsl, st,
                       input logic [15:0] itm, ei, input int eh, es, input string what);
    sync_tick();
    wr(`PTL_OFS_TARGET, tgt);
    wr(`PTL_OFS_ISIGN, 16'(isg));
    wr(`PTL_OFS_IRATE, 16'(irt));
    wr(`PTL_OFS_IWINDOW, 16'(win));
    wr(`PTL_OFS_WSELECT, 16'(wsl));
    wr(`PTL_OFS_ITIME, itm);
    sat_cmd = 1'(st);
    wr(`PTL_OFS_CLEAR, 16'h0001);
    wr(`PTL_OFS_CLEAR, 16'h0000);
    sync_tick();
    chk(status.integ, ei, what);
    chk(status.out, ei, what);
    chk({15'h0000, status.integ_hold}, 16'(eh), what);
    chk({15'h0000, status.integ_sat}, 16'(es), what);
  endtask

  task automatic t_integ();
    wr(`PTL_OFS_PGAIN, 16'h0000);
    wr(`PTL_OFS_IZERO, 16'h0000);
    wr(`PTL_OFS_ENABLE, 16'h0001);
    icase(16'h03e8, 1, 0, 0, 0, 0, 16'h0064, 16'h0064, 0, 0, "linear");
    icase(16'h03e8, 1, 1, 0, 0, 0, 16'h0064, 16'h000a, 0, 0, "standard");
    icase(16'h07d0, 1, 1, 0, 0, 0, 16'h0064, 16'h0014, 0, 0, "standard x2");
    icase(16'hfc18, 1, 0, 0, 0, 0, 16'h0064, 16'hff9c, 0, 0, "bipolar");
    icase(16'hfc18, 0, 0, 0, 0, 0, 16'h0064, 16'h0000, 0, 0, "unipolar");
    icase(16'h03e8, 1, 0, 16'h03e8, 0, 0, 16'h0064, 16'h0000, 0, 0, "in window");
    icase(16'h03e8, 1, 0, 16'h03e7, 0, 0, 16'h0064, 16'h0064, 0, 0, "out window");
    icase(16'hfc18, 1, 0, 0, 1, 1, 16'h0064, 16'h0000, 1, 0, "held");
    icase(16'hfc18, 1, 0, 0, 1, 0, 16'h0064, 16'hff9c, 0, 0, "not saturated");
    icase(16'hfc18, 1, 0, 0, 0, 1, 16'h0064, 16'hff9c, 0, 0, "monitor off");
    icase(16'h03e8, 1, 0, 0, 0, 0, 16'h0001, 16'h2710, 0, 1, "top limit");
    icase(16'hfc18, 1, 0, 0, 0, 0, 16'h0001, 16'hd8f0, 0, 1, "bottom limit");
    $display("test integ done");
  endtask

  // A long sampling interval keeps the derivative standing across a whole update tick.
  task automatic t_deriv();
    wr(`PTL_OFS_IZERO, 16'h0001);
    wr(`PTL_OFS_DLEVEL, 16'h2710);
    wr(`PTL_OFS_DINTERVAL, 16'h0096);
    wr(`PTL_OFS_TARGET, 16'h0000);
    wr(`PTL_OFS_CLEAR, 16'h0001);
    sync_tick();
    wr(`PTL_OFS_CLEAR, 16'h0000);
    wr(`PTL_OFS_TARGET, 16'h03e8);
    sync_tick();
    chk(status.deriv, 16'h0000, "before first sample");
    sync_tick();
    chk(status.deriv, 16'h03e8, "derivative step");
    chk(status.out, 16'h03e8, "derivative output");
    $display("test deriv done");
  endtask

  initial begin
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    t_reset();
    t_error();
    t_prop();
    t_off();
    t_integ();
    t_deriv();
    finish_test();
  end

  // The tests need about 15000 cycles; the limit allows well over twice that.
  initial begin
    #200000;
    n_fail++;
    $display("BAD %0t watchdog expired", $time);
    finish_test();
  end
endmodule
